// File: core/slcd_pkg.sv
package slcd_pkg;
	// register indices on the plain register port
	localparam logic [5:0] REG_PIN_CTRL = 6'h00;
	localparam logic [5:0] REG_PANEL_CTRL = 6'h01;
	localparam logic [5:0] REG_SUPPLY_CTRL = 6'h02;
	localparam logic [5:0] REG_RAM_BASE = 6'h20;
	localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
	localparam logic [7:0] PANEL_CTRL_RESET = 8'h80;
	localparam logic [7:0] SUPPLY_CTRL_RESET = 8'h60;
	// pin control fields
	localparam int DUTY_HI_BIT = 7;
	localparam int DUTY_LO_BIT = 6;
	localparam int COM_PAR_BIT = 5;
	localparam int EXP_BIT = 4;
	localparam int DRV_SEL_MSB = 3;
	// panel control fields
	localparam int SUPPLY_ON_BIT = 6;
	localparam int RUN_BIT = 5;
	localparam int SHOW_BIT = 4;
	localparam int FCLK_MSB = 3;
	// supply control fields
	localparam int WAVE_B_BIT = 7;
	localparam int BOOST_BIT = 4;
	localparam int CDS_MSB = 3;
	localparam int RAM_BYTES = 32;
	localparam int SEG_PINS = 32;
	localparam int COM_PINS = 4;
	// base frame step rate from the 200 MHz clock, the watch clock is modeled as an enable
	localparam int CLK_HZ = 200_000_000;
	localparam int BASE_STEP_HZ = 1_000_000;
	localparam int BASE_STEP_CYC = CLK_HZ / BASE_STEP_HZ;
	typedef enum logic [1:0] {
		SLCD_DUTY_STATIC = 2'b00,
		SLCD_DUTY_HALF = 2'b01,
		SLCD_DUTY_THIRD = 2'b10,
		SLCD_DUTY_QUARTER = 2'b11
	} slcd_duty_t;
	typedef enum logic [1:0] {
		SLCD_ST_IDLE = 2'b00,
		SLCD_ST_SCAN = 2'b01,
		SLCD_ST_SHIFT = 2'b11
	} slcd_state_t;
	typedef struct packed {
		logic latch;
		logic shift;
		logic data;
		logic alt;
	} slcd_exp_t;
endpackage : slcd_pkg

// File: core/slcd_ctrl.sv
// Summary of operation
// R1 - static, 1/2, 1/3, 1/4 duty select
// R2 - 32 internal segments; expansion 256/128/64; the code shifts 32 bits per common at every duty
// R3 - 32-byte display memory as RAM
// R4 - byte and 16-bit word writes accepted
// R5 - segment pins become ports by eights
// R6 - spare commons mirror waveform at static/half
// R7 - drive continues except in standby
// R8 - eleven frame clock choices
// R9 - module standby stops block independently
// R10 - waveform type selects A or B
// R11 - pin control register resets 00
// R12 - panel control register resets 80
// R13 - supply control register resets 60
// R14 - latch strobe on top segment pin
// R15 - shift strobe on segment 31 pin
// R16 - alternation on segment 29 pin
// R17 - serial data on segment 30 pin
// R18 - scanning starts automatically once enabled
// R19 - bit one lights, zero leaves unlit
// R20 - boost select enables step-up supply
// R21 - external supply: software clears boost, supply
// R22 - static: one common, 32 direct segments
// R23 - show bit zero drives blank data
// R24 - run clear halts, forces supply off
// R25 - alternation toggles every frame
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module slcd_ctrl
	import slcd_pkg::*;
#(
	parameter int STEP_CYC = BASE_STEP_CYC
) (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [5:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WORD_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [15:0] RDATA_O,
	input wire logic STANDBY_I,
	input wire logic MODULE_STBY_I,
	input wire logic WATCH_TICK_I,
	output logic [COM_PINS-1:0] COM_LEVEL_O,
	output logic [COM_PINS-1:0] COM_ACTIVE_O,
	output logic [SEG_PINS-1:0] SEG_LEVEL_O,
	output logic [SEG_PINS-1:0] SEG_IS_PORT_O,
	output logic ALT_O,
	output logic WAVE_B_O,
	output logic SUPPLY_ON_O,
	output logic BOOST_ON_O,
	output logic [3:0] CDS_O
);
	// a zero step count would leave the divider without a terminal value
	if (STEP_CYC < 1) begin : g_bad_step
		$error("STEP_CYC must be at least one");
	end

	logic [7:0] pin_control_reg;
	logic [7:0] panel_control_reg;
	logic [7:0] supply_control_reg;
	logic [7:0] ram [RAM_BYTES];
	logic ram_hit;
	logic [4:0] ram_idx;
	logic running;
	slcd_duty_t duty;
	slcd_state_t state;
	logic [31:0] step_cnt;
	logic base_tick;
	logic [7:0] div_cnt;
	logic frame_step;
	logic [1:0] com_idx;
	logic [1:0] com_last;
	logic [4:0] shift_cnt;
	slcd_exp_t exp_sig;
	logic [SEG_PINS-1:0] seg_data;

	assign ram_hit = ADDR_I >= REG_RAM_BASE;
	assign ram_idx = ADDR_I[4:0];
	assign duty = slcd_duty_t'(pin_control_reg[DUTY_HI_BIT:DUTY_LO_BIT]);
	// blocked in standby, module standby or when run is clear
	assign running = panel_control_reg[RUN_BIT] && !STANDBY_I && !MODULE_STBY_I; // R7 R9 R24

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			pin_control_reg <= PIN_CTRL_RESET; // R11
			panel_control_reg <= PANEL_CTRL_RESET; // R12
			supply_control_reg <= SUPPLY_CTRL_RESET; // R13
		end else if (WR_I && !ram_hit) begin
			case (ADDR_I)
				REG_PIN_CTRL: begin
					// expansion with any driver select is illegal; keep drive selection clear
					pin_control_reg <= WDATA_I[EXP_BIT] ? {WDATA_I[7:4], 4'h0} : WDATA_I[7:0];
				end
				REG_PANEL_CTRL: panel_control_reg <= WDATA_I[7:0];
				REG_SUPPLY_CTRL: supply_control_reg <= WDATA_I[7:0];
				default: ;
			endcase
		end
	end

	// word writes land on an even pair, high byte first as on a big-endian cpu
	always_ff @(posedge CLK_I) begin
		if (WR_I && ram_hit) begin
			if (WORD_I) begin // R4
				ram[{ram_idx[4:1], 1'b0}] <= WDATA_I[15:8];
				ram[{ram_idx[4:1], 1'b1}] <= WDATA_I[7:0];
			end else begin
				ram[ram_idx] <= WDATA_I[7:0]; // R3
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			RDATA_O <= 16'h0000;
		end else if (RD_I) begin
			if (ram_hit && WORD_I) RDATA_O <= {ram[{ram_idx[4:1], 1'b0}], ram[{ram_idx[4:1], 1'b1}]};
			else if (ram_hit) RDATA_O <= {8'h00, ram[ram_idx]};
			else begin
				case (ADDR_I)
					REG_PIN_CTRL: RDATA_O <= {8'h00, pin_control_reg};
					REG_PANEL_CTRL: RDATA_O <= {8'h00, panel_control_reg};
					REG_SUPPLY_CTRL: RDATA_O <= {8'h00, supply_control_reg};
					default: RDATA_O <= 16'h0000;
				endcase
			end
		end
	end

	// base step divider; the watch clock path uses the external tick instead
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I || !running) begin
			step_cnt <= 32'h0;
			base_tick <= 1'b0;
		end else if (step_cnt == 32'(STEP_CYC - 1)) begin
			step_cnt <= 32'h0;
			base_tick <= 1'b1;
		end else begin
			step_cnt <= step_cnt + 32'h1;
			base_tick <= 1'b0;
		end
	end

	function automatic logic [7:0] fclk_mask(input logic [3:0] sel);
		case (sel)
			4'b1000: fclk_mask = 8'h00;
			4'b1001: fclk_mask = 8'h01;
			4'b1010: fclk_mask = 8'h03;
			4'b1011: fclk_mask = 8'h07;
			4'b1100: fclk_mask = 8'h0F;
			4'b1101: fclk_mask = 8'h1F;
			4'b1110: fclk_mask = 8'h3F;
			4'b1111: fclk_mask = 8'h7F;
			default: fclk_mask = sel[1] ? 8'h03 : {7'h00, sel[0]};
		endcase
	endfunction

	// eleven rates: three on the watch tick, eight on the system divider
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I || !running) begin
			div_cnt <= 8'h00;
			frame_step <= 1'b0;
		end else begin
			frame_step <= 1'b0;
			if (panel_control_reg[FCLK_MSB] ? base_tick : WATCH_TICK_I) begin // R8
				if ((div_cnt & fclk_mask(panel_control_reg[FCLK_MSB:0])) ==
					fclk_mask(panel_control_reg[FCLK_MSB:0])) begin
					div_cnt <= 8'h00;
					frame_step <= 1'b1;
				end else begin
					div_cnt <= div_cnt + 8'h01;
				end
			end
		end
	end

	assign com_last = duty; // R1

	// scan machine: steps commons and, in expansion, shifts data after each common
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I || !running) begin
			state <= SLCD_ST_IDLE;
			com_idx <= 2'b00;
			shift_cnt <= 5'h00;
			exp_sig <= '0;
		end else begin
			case (state)
				SLCD_ST_IDLE: state <= SLCD_ST_SCAN; // R18
				SLCD_ST_SCAN: begin
					exp_sig.latch <= 1'b0;
					if (frame_step) begin
						// wrap also when duty was lowered while a higher common was active
						if (com_idx >= com_last) begin
							com_idx <= 2'b00;
							exp_sig.alt <= ~exp_sig.alt; // R25 R16
						end else begin
							com_idx <= com_idx + 2'b01;
						end
						if (pin_control_reg[EXP_BIT]) begin
							state <= SLCD_ST_SHIFT;
							shift_cnt <= 5'h00;
						end
					end
				end
				SLCD_ST_SHIFT: begin
					// one bit per two clocks; capacity per common is fixed at 32 bits, shift_cnt 0 to 31
					exp_sig.shift <= ~exp_sig.shift; // R15
					if (!exp_sig.shift) begin
						exp_sig.data <= panel_control_reg[SHOW_BIT] &
							ram[shift_cnt][com_idx + {1'b0, shift_cnt[0]}]; // R17
					end else begin
						shift_cnt <= shift_cnt + 5'h01;
						if (shift_cnt == 5'h1F) begin
							exp_sig.latch <= 1'b1; // R14 R2
							state <= SLCD_ST_SCAN;
						end
					end
				end
				default: state <= SLCD_ST_IDLE;
			endcase
		end
	end

	// segment data for the current common; static maps all eight bits of bytes 0 to 3
	always_comb begin
		seg_data = '0;
		for (int s = 0; s < SEG_PINS; s++) begin
			if (duty == SLCD_DUTY_STATIC)
				seg_data[s] = ram[s / 8][s % 8]; // R22 R19
			else
				seg_data[s] = ram[s][{1'b0, com_idx}]; // R19
			seg_data[s] = seg_data[s] & panel_control_reg[SHOW_BIT]; // R23
		end
	end

	genvar g;
	generate
		for (g = 0; g < SEG_PINS / 8; g++) begin : g_port
			// group g covers pins 8g..8g+7; higher groups stay drivers first
			always_ff @(posedge CLK_I) begin
				if (!RST_N_I) SEG_IS_PORT_O[g*8 +: 8] <= 8'hFF;
				else if (pin_control_reg[EXP_BIT])
					SEG_IS_PORT_O[g*8 +: 8] <= (g == SEG_PINS / 8 - 1) ? 8'h0F : 8'hFF; // R5 R14
				else if (pin_control_reg[DRV_SEL_MSB])
					SEG_IS_PORT_O[g*8 +: 8] <= 8'h00;
				else SEG_IS_PORT_O[g*8 +: 8] <= {8{(3'(g) + pin_control_reg[2:1]) < 3'd4}}; // R5
			end
		end
	endgenerate

	// level = data xor alternation so average voltage stays zero
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			SEG_LEVEL_O <= '0;
			COM_LEVEL_O <= '0;
			COM_ACTIVE_O <= '0;
		end else if (!running) begin
			SEG_LEVEL_O <= '0;
			COM_LEVEL_O <= '0;
			COM_ACTIVE_O <= '0;
		end else begin
			SEG_LEVEL_O <= seg_data ^ {SEG_PINS{exp_sig.alt}};
			if (pin_control_reg[EXP_BIT]) begin
				SEG_LEVEL_O[31] <= exp_sig.latch; // R14
				SEG_LEVEL_O[30] <= exp_sig.shift; // R15
				SEG_LEVEL_O[29] <= exp_sig.data; // R17
				SEG_LEVEL_O[28] <= exp_sig.alt; // R16
			end
			for (int c = 0; c < COM_PINS; c++) begin
				COM_ACTIVE_O[c] <= (2'(c) == com_idx) ||
					(pin_control_reg[COM_PAR_BIT] && !duty[1] && 2'(c) > com_last); // R6
				COM_LEVEL_O[c] <= exp_sig.alt;
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			ALT_O <= 1'b0;
			WAVE_B_O <= 1'b0;
			SUPPLY_ON_O <= 1'b0;
			BOOST_ON_O <= 1'b0;
			CDS_O <= 4'h0;
		end else begin
			ALT_O <= exp_sig.alt;
			WAVE_B_O <= supply_control_reg[WAVE_B_BIT]; // R10
			SUPPLY_ON_O <= running && panel_control_reg[SUPPLY_ON_BIT]; // R24 R21
			BOOST_ON_O <= running && supply_control_reg[BOOST_BIT]; // R20
			CDS_O <= supply_control_reg[CDS_MSB:0];
		end
	end
endmodule : slcd_ctrl
`default_nettype wire

// File: dv/slcd_panel.sv
`timescale 1ns/1ps
`default_nettype none
module slcd_panel
	import slcd_pkg::*;
(
	input wire logic clk_i,
	input wire logic [COM_PINS-1:0] com_i,
	input wire logic [SEG_PINS-1:0] seg_i,
	input wire logic [SEG_PINS-1:0] port_i,
	input wire logic alt_i,
	output logic [SEG_PINS-1:0] lit_o,
	output logic [15:0] flips_o
);
	logic alt_d = 1'b0;
	// glass lights where column and backplane phases differ
	assign lit_o = (seg_i ^ {SEG_PINS{alt_i}}) & ~port_i & {SEG_PINS{|com_i}};
	initial flips_o = 16'h0000;
	always @(posedge clk_i) begin
		alt_d <= alt_i;
		flips_o <= flips_o + 16'(alt_d != alt_i);
	end
endmodule : slcd_panel
`default_nettype wire

// File: dv/slcd_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module slcd_chk
	import slcd_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [5:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [15:0] RDATA_O,
	input wire logic STANDBY_I,
	input wire logic MODULE_STBY_I,
	input wire logic [COM_PINS-1:0] COM_ACTIVE_O,
	input wire logic [SEG_PINS-1:0] SEG_LEVEL_O,
	input wire logic [SEG_PINS-1:0] SEG_IS_PORT_O,
	input wire logic ALT_O,
	input wire logic WAVE_B_O,
	input wire logic SUPPLY_ON_O,
	input wire logic BOOST_ON_O
);
	logic [7:0] pin, pan, sup, rsel;
	logic live;
	// shadow registers rebuilt from the write port, so no body signal is needed
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			pin <= 8'h00;
			pan <= 8'h80;
			sup <= 8'h60;
		end else if (WR_I && ADDR_I == REG_PIN_CTRL) begin
			pin <= WDATA_I[4] ? {WDATA_I[7:4], 4'h0} : WDATA_I[7:0];
		end else if (WR_I && ADDR_I == REG_PANEL_CTRL) begin
			pan <= WDATA_I[7:0];
		end else if (WR_I && ADDR_I == REG_SUPPLY_CTRL) begin
			sup <= WDATA_I[7:0];
		end
	end
	assign rsel = ADDR_I == REG_PIN_CTRL ? pin : ADDR_I == REG_PANEL_CTRL ? pan : sup;
	assign live = pan[RUN_BIT] && !STANDBY_I && !MODULE_STBY_I;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	a_reg_read: assert property (RD_I && ADDR_I < 6'h03 |=> RDATA_O[7:0] == $past(rsel))
		else $error("register read wrong");
	a_read_holds: assert property (!RD_I |=> $stable(RDATA_O))
		else $error("read data moved");
	a_halt_off: assert property ((!live) [*4] |-> !SUPPLY_ON_O && $stable(ALT_O))
		else $error("halted block still drives");
	a_supply_on: assert property ((live && pan[SUPPLY_ON_BIT]) [*3] |-> SUPPLY_ON_O)
		else $error("supply not on");
	a_wave_boost: assert property ((live && $stable(sup)) [*3] |->
		WAVE_B_O == sup[WAVE_B_BIT] && BOOST_ON_O == sup[BOOST_BIT]) else $error("supply ctrl");
	a_port_groups: assert property ($stable(pin) [*3] |-> SEG_IS_PORT_O ==
		(pin[EXP_BIT] ? 32'h0FFFFFFF : pin[DRV_SEL_MSB] ? 32'h00000000 :
		32'hFFFFFFFF >> {pin[2:1], 3'b000})) else $error("port groups wrong");
	a_duty_commons: assert property ((live && $stable(pin) && !pin[COM_PAR_BIT]) [*3] |->
		$onehot0(COM_ACTIVE_O) && (COM_ACTIVE_O >> ({1'b0, pin[7:6]} + 3'd1)) == 4'h0)
		else $error("common outside duty");
	a_exp_alt: assert property ((live && pin[EXP_BIT]) [*3] |->
		SEG_LEVEL_O[28] == ALT_O || $changed(ALT_O)) else $error("alternation pin wrong");
endmodule : slcd_chk
bind slcd_ctrl slcd_chk u_chk (.CLK_I, .RST_N_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
	.STANDBY_I, .MODULE_STBY_I, .COM_ACTIVE_O, .SEG_LEVEL_O, .SEG_IS_PORT_O, .ALT_O,
	.WAVE_B_O, .SUPPLY_ON_O, .BOOST_ON_O);
`default_nettype wire

// File: dv/segment_lcd_controller_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module segment_lcd_controller_tb_top;
	import slcd_pkg::*;
	logic clk = 0, rst_n = 0, word = 0, wr = 0, rd = 0, stby = 0, mstby = 0, tick = 0;
	logic [5:0] addr = 6'h00;
	logic [15:0] wdata = 16'h0000, rdata, flips;
	logic [31:0] panel_column_outputs, port, lit;
	logic [3:0] com_act;
	logic alt, sup_on;
	int bad_count = 0, total_checks = 0, i, n30, n31;
	always #2.5 clk = ~clk;
	always @(posedge clk) tick <= ~tick;
	slcd_ctrl #(.STEP_CYC(2)) dut (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
		.WORD_I(word), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .STANDBY_I(stby),
		.MODULE_STBY_I(mstby), .WATCH_TICK_I(tick), .COM_LEVEL_O(), .COM_ACTIVE_O(com_act),
		.SEG_LEVEL_O(panel_column_outputs), .SEG_IS_PORT_O(port), .ALT_O(alt), .WAVE_B_O(),
		.SUPPLY_ON_O(sup_on), .BOOST_ON_O(), .CDS_O());
	slcd_panel u_panel (.clk_i(clk), .com_i(com_act), .seg_i(panel_column_outputs), .port_i(port), .alt_i(alt),
		.lit_o(lit), .flips_o(flips));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up
	task automatic wreg(input logic [5:0] a, input logic [15:0] d, input logic w);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		word <= w;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [5:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		word <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(32'(rdata[7:0]), 32'(e));
	endtask : rreg
	// bounded wait on alternation flips seen by the panel
	task automatic frames(input int n);
		logic [15:0] f0;
		int k;
		f0 = flips;
		for (k = 0; k < 20000 && flips - f0 < 16'(n); k++)
			@(posedge clk);
		#1;
		if (k == 20000) begin
			chk(32'h1, 32'h0);
			wrap_up();
		end
	endtask : frames
	task automatic settle;
		repeat (4) @(posedge clk);
		#1;
	endtask : settle
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rreg(REG_PIN_CTRL, 8'h00);
		rreg(REG_PANEL_CTRL, 8'h80);
		rreg(REG_SUPPLY_CTRL, 8'h60);
		rreg(6'h10, 8'h00);
		for (i = 0; i < 4; i++) begin
			wreg(REG_PIN_CTRL, 16'(2 * i), 1'b0);
			settle();
			chk(port, 32'hFFFFFFFF >> (8 * i));
		end
		wreg(REG_SUPPLY_CTRL, 16'h009F, 1'b0);
		rreg(REG_SUPPLY_CTRL, 8'h9F);
		wreg(REG_PIN_CTRL, 16'h0008, 1'b0);
		for (i = 0; i < 32; i += 2)
			wreg(REG_RAM_BASE + 6'(i), 16'hFFFF, 1'b1);
		wreg(REG_PANEL_CTRL, 16'h0078, 1'b0);
		frames(2);
		chk(lit, 32'hFFFFFFFF);
		chk(32'(com_act), 32'h1);
		wreg(REG_PANEL_CTRL, 16'h0068, 1'b0);
		frames(1);
		chk(lit, 32'h0);
		wreg(REG_RAM_BASE, 16'hA55A, 1'b1);
		rreg(REG_RAM_BASE, 8'hA5);
		rreg(REG_RAM_BASE + 6'h01, 8'h5A);
		for (i = 0; i < 32; i++)
			wreg(REG_RAM_BASE + 6'(i), 16'h0000, 1'b0);
		wreg(REG_PANEL_CTRL, 16'h0078, 1'b0);
		frames(1);
		chk(lit, 32'h0);
		wreg(REG_PIN_CTRL, 16'h001F, 1'b0);
		rreg(REG_PIN_CTRL, 8'h10);
		frames(2);
		n30 = 0;
		n31 = 0;
		for (i = 0; i < 400; i++) begin
			@(posedge clk);
			n30 += int'(panel_column_outputs[30]);
			n31 += int'(panel_column_outputs[31]);
		end
		chk(32'(n30 > 0 && n30 < 400 && n31 > 0 && n31 < 400), 32'h1);
		for (i = 0; i < 4; i++) begin
			wreg(REG_PIN_CTRL, 16'(64 * i + 8), 1'b0);
			frames(2);
			chk(32'(com_act >> (i + 1)), 32'h0);
		end
		wreg(REG_PIN_CTRL, 16'h0028, 1'b0);
		frames(1);
		chk(32'(com_act), 32'hF);
		for (i = 0; i < 16; i++)
			if (i < 3 || i > 7) begin
				wreg(REG_PANEL_CTRL, 16'(112 + i), 1'b0);
				frames(2);
			end
		@(posedge clk);
		stby <= 1'b1;
		settle();
		chk(32'(sup_on), 32'h0);
		stby <= 1'b0;
		mstby <= 1'b1;
		settle();
		chk(32'(sup_on), 32'h0);
		mstby <= 1'b0;
		wreg(REG_SUPPLY_CTRL, 16'h000F, 1'b0);
		wreg(REG_PANEL_CTRL, 16'h0058, 1'b0);
		settle();
		chk(32'(sup_on), 32'h0);
		rreg(REG_PANEL_CTRL, 8'h58);
		wrap_up();
	end
endmodule : segment_lcd_controller_tb_top
`default_nettype wire
